// [hdl/msd_top.sv]
// serial setting decoder with apb access and channel 5/6 gating
`timescale 1ns/10ps
`default_nettype none
module msd_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ch5_parallel_ctrl_a,
   input  wire logic        ch5_parallel_ctrl_b,
   input  wire logic        ch6_parallel_ctrl_a,
   input  wire logic        ch6_parallel_ctrl_b,
   input  wire logic        step_clock_or_pwm_input,
   input  wire logic        drive_fwd,
   input  wire logic        drive_rev,
   output logic      [3:0]  ch5_current_level,
   output logic      [3:0]  ch6_current_level,
   output logic             photosensor_drive_output,
   output logic             schmitt_buffer_one_hyst,
   output logic             schmitt_buffer_two_hyst,
   output logic             schmitt_buffer_three_hyst,
   output logic             step_clock_out,
   output logic      [1:0]  bridge_out
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   msd_pkg::msd_phase_t phase;
   msd_pkg::msd_phase_t next_phase;

   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;

   logic [7:0]  setting;
   logic [7:0]  next_setting;
   logic [3:0]  ch5_level;
   logic [3:0]  next_ch5_level;
   logic [3:0]  ch6_level;
   logic [3:0]  next_ch6_level;
   logic        photo;
   logic        next_photo;
   logic [2:0]  hyst;
   logic [2:0]  next_hyst;
   logic        pwm_mode;
   logic        next_pwm_mode;
   logic        brake_sel;
   logic        next_brake_sel;
   logic        standby_sel;
   logic        next_standby_sel;
   logic [7:0]  discard_cnt;
   logic [7:0]  next_discard_cnt;

   logic        setup_cyc;
   logic        access_cyc;
   logic        wr_setting;
   logic        wr_discard;
   logic        addr_hit;
   logic [2:0]  word_mode;
   logic [3:0]  word_level;
   logic        word_ch6;
   logic        word_dropped;
   logic [31:0] status_word;

   ////////////////////////////////////////////////////////////////////////////
   // apb phase tracking

   // setup is judged from the bus; the phase register remembers that a
   // setup was seen, so an access is only honoured right behind one and a
   // stray penable with a stale ready can never commit a write
   assign setup_cyc  = psel & ~penable;
   assign access_cyc = psel & penable & pready
                       & (phase == msd_pkg::PH_SETUP);

   always_comb begin
      case (phase)
         msd_pkg::PH_IDLE: begin
            next_phase = setup_cyc ? msd_pkg::PH_SETUP : msd_pkg::PH_IDLE;
         end
         msd_pkg::PH_SETUP: begin
            next_phase = msd_pkg::PH_ACCESS;
         end
         msd_pkg::PH_ACCESS: begin
            next_phase = setup_cyc ? msd_pkg::PH_SETUP : msd_pkg::PH_IDLE;
         end
         default: begin
            next_phase = msd_pkg::PH_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= msd_pkg::PH_IDLE;
      end else begin
         phase <= next_phase;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // address decode

   // only the three aligned words answer; anything else is a slave error
   always_comb begin
      case (paddr)
         msd_pkg::ADDR_SETTING: addr_hit = 1'b1;
         msd_pkg::ADDR_STATUS:  addr_hit = 1'b1;
         msd_pkg::ADDR_DISCARD: addr_hit = 1'b1;
         default:               addr_hit = 1'b0;
      endcase
   end

   // a setting word lives in byte lane 0, so a write without it is a no-op
   assign wr_setting = access_cyc & pwrite & pstrb[0] & (paddr == msd_pkg::ADDR_SETTING);
   assign wr_discard = access_cyc & pwrite & (paddr == msd_pkg::ADDR_DISCARD);

   ////////////////////////////////////////////////////////////////////////////
   // setting word fields

   // d0 sits in bit 0 and the mode codes are packed the same way, so the
   // mode bits are taken in place; reversing them would swap d0 and d2
   assign word_mode  = pwdata[msd_pkg::MODE_LSB +: 3];
   // reference level, d3 is its least significant bit
   assign word_level = pwdata[msd_pkg::LEVEL_LSB +: 4];
   // d7 low picks ch5, high picks ch6
   assign word_ch6   = pwdata[msd_pkg::CHSEL_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // setting decode

   // current words for a channel whose parallel inputs are busy are dropped
   // and counted; a word in a mode other than current, aux or drive only updates the readback copy
   always_comb begin
      next_setting     = setting;
      next_ch5_level   = ch5_level;
      next_ch6_level   = ch6_level;
      next_photo       = photo;
      next_hyst        = hyst;
      next_pwm_mode    = pwm_mode;
      next_brake_sel   = brake_sel;
      next_standby_sel = standby_sel;
      word_dropped     = 1'b0;
      if (wr_setting) begin
         next_setting = pwdata[7:0];
         case (word_mode)
            msd_pkg::MODE_CURRENT: begin
               if (!word_ch6) begin
                  if (msd_pkg::ch_open(ch5_parallel_ctrl_a, ch5_parallel_ctrl_b)) begin
                     next_ch5_level = word_level;
                  end else begin
                     word_dropped = 1'b1;
                  end
               end else begin
                  if (msd_pkg::ch_open(ch6_parallel_ctrl_a, ch6_parallel_ctrl_b)) begin
                     next_ch6_level = word_level;
                  end else begin
                     word_dropped = 1'b1;
                  end
               end
            end
            msd_pkg::MODE_AUX: begin
               next_photo = pwdata[msd_pkg::PHOTO_BIT];
               next_hyst  = pwdata[msd_pkg::HYST_LSB +: 3];
            end
            msd_pkg::MODE_DRIVE: begin
               next_pwm_mode    = pwdata[msd_pkg::PWM_BIT];
               next_brake_sel   = pwdata[msd_pkg::BRAKE_BIT];
               next_standby_sel = pwdata[msd_pkg::STBY_BIT];
            end
            default: begin
               next_setting = pwdata[7:0];   // other modes belong elsewhere
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // discard counter

   // saturates so software never misreads a wrap as few drops; a drop in
   // the clearing cycle still counts as one
   always_comb begin
      next_discard_cnt = discard_cnt;
      if (wr_discard) begin
         next_discard_cnt = msd_pkg::DISCARD_RST;
      end
      if (word_dropped && (next_discard_cnt != 8'hff)) begin
         next_discard_cnt = next_discard_cnt + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // setting state registers

   // everything starts cleared: step clock use, no overrides, lowest
   // level code, so the bridge follows drive_fwd and drive_rev with no pin override until software speaks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         setting     <= msd_pkg::SETTING_RST;
         ch5_level   <= msd_pkg::LEVEL_RST;
         ch6_level   <= msd_pkg::LEVEL_RST;
         photo       <= 1'b0;
         hyst        <= msd_pkg::HYST_RST;
         pwm_mode    <= 1'b0;
         brake_sel   <= 1'b0;
         standby_sel <= 1'b0;
         discard_cnt <= msd_pkg::DISCARD_RST;
      end else begin
         setting     <= next_setting;
         ch5_level   <= next_ch5_level;
         ch6_level   <= next_ch6_level;
         photo       <= next_photo;
         hyst        <= next_hyst;
         pwm_mode    <= next_pwm_mode;
         brake_sel   <= next_brake_sel;
         standby_sel <= next_standby_sel;
         discard_cnt <= next_discard_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[msd_pkg::ST_CH5_LSB +: 4]  = ch5_level;
      status_word[msd_pkg::ST_CH6_LSB +: 4]  = ch6_level;
      status_word[msd_pkg::ST_PHOTO]         = photo;
      status_word[msd_pkg::ST_HYST_LSB +: 3] = hyst;
      status_word[msd_pkg::ST_PWM]           = pwm_mode;
      status_word[msd_pkg::ST_BRAKE]         = brake_sel;
      status_word[msd_pkg::ST_STBY]          = standby_sel;
   end

   // read data and error are captured in setup so they leave a flop;
   // pready rises in setup, giving a fixed zero-wait access;
   // an unmapped word reads as zero alongside the error
   always_comb begin
      next_prdata  = prdata;
      next_pready  = 1'b0;
      next_pslverr = 1'b0;
      if (setup_cyc) begin
         next_pready  = 1'b1;
         next_pslverr = ~addr_hit;
         case (paddr)
            msd_pkg::ADDR_SETTING: next_prdata = {24'h00_0000, setting};
            msd_pkg::ADDR_STATUS:  next_prdata = status_word;
            msd_pkg::ADDR_DISCARD: next_prdata = {24'h00_0000, discard_cnt};
            default:               next_prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // setting outputs, straight from the state flops

   // buffer one takes d4, two d5, three d6 of an aux word
   assign ch5_current_level         = ch5_level;
   assign ch6_current_level         = ch6_level;
   assign photosensor_drive_output  = photo;
   assign schmitt_buffer_one_hyst   = hyst[0];
   assign schmitt_buffer_two_hyst   = hyst[1];
   assign schmitt_buffer_three_hyst = hyst[2];

   ////////////////////////////////////////////////////////////////////////////
   // bridge drive

   // pin handling kept apart so its one-cycle latency sits in one place
   msd_drive_ctrl msd_drive_ctrl_inst (
      .pclk                    (pclk),
      .presetn                 (presetn),
      .pwm_mode                (pwm_mode),
      .brake_sel               (brake_sel),
      .standby_sel             (standby_sel),
      .step_clock_or_pwm_input (step_clock_or_pwm_input),
      .drive_fwd               (drive_fwd),
      .drive_rev               (drive_rev),
      .bridge                  (bridge_out),
      .step_clock              (step_clock_out)
   );

endmodule : msd_top
`default_nettype wire

// [hdl/msd_pkg.sv]
// constants, encodings and helpers for the motor driver serial setting block
`default_nettype none
package msd_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // apb register map, byte addresses of aligned words
   localparam logic [7:0] ADDR_SETTING = 8'h00;
   localparam logic [7:0] ADDR_STATUS  = 8'h04;
   localparam logic [7:0] ADDR_DISCARD = 8'h08;

   ////////////////////////////////////////////////////////////////////////////
   // setting word layout, d0 in bit 0
   localparam int MODE_LSB  = 0;   // d0..d2 select the setting mode
   localparam int LEVEL_LSB = 3;   // d3..d6 reference level
   localparam int CHSEL_BIT = 7;   // d7 channel select, 0 = ch5
   localparam int PHOTO_BIT = 3;   // photosensor drive on
   localparam int HYST_LSB  = 4;   // d4..d6 hysteresis of buffers one..three
   localparam int PWM_BIT   = 3;   // drive word: 1 = pwm, 0 = step clock
   localparam int BRAKE_BIT = 4;   // drive word: high pin forces brake
   localparam int STBY_BIT  = 5;   // drive word: high pin forces standby

   // setting mode codes, d0 first
   localparam logic [2:0] MODE_CURRENT = 3'h6;  // d0=0 d1=1 d2=1
   localparam logic [2:0] MODE_AUX     = 3'h7;  // d0=1 d1=1 d2=1
   localparam logic [2:0] MODE_DRIVE   = 3'h1;  // d0=1 d1=0 d2=0

   ////////////////////////////////////////////////////////////////////////////
   // status register fields
   localparam int ST_CH5_LSB  = 0;
   localparam int ST_CH6_LSB  = 4;
   localparam int ST_PHOTO    = 8;
   localparam int ST_HYST_LSB = 9;
   localparam int ST_PWM      = 12;
   localparam int ST_BRAKE    = 13;
   localparam int ST_STBY     = 14;

   ////////////////////////////////////////////////////////////////////////////
   // values after reset
   localparam logic [3:0] LEVEL_RST   = 4'h0;   // 0.200 v code
   localparam logic [7:0] SETTING_RST = 8'h00;
   localparam logic [2:0] HYST_RST    = 3'h0;
   localparam logic [7:0] DISCARD_RST = 8'h00;

   // h-bridge output pairs, a then b
   localparam logic [1:0] BRIDGE_BRAKE = 2'h3;
   localparam logic [1:0] BRIDGE_STBY  = 2'h0;
   localparam logic [1:0] BRIDGE_FWD   = 2'h2;
   localparam logic [1:0] BRIDGE_REV   = 2'h1;

   // apb phase tracker
   typedef enum logic [2:0] {
      PH_IDLE   = 3'b001,
      PH_SETUP  = 3'b010,
      PH_ACCESS = 3'b100
   } msd_phase_t;

   // a channel accepts serial settings only with both parallel inputs low
   function automatic logic ch_open(input logic ctrl_a, input logic ctrl_b);
      ch_open = ~ctrl_a & ~ctrl_b;
   endfunction : ch_open

endpackage : msd_pkg
`default_nettype wire

// [hdl/msd_drive_ctrl.sv]
// h-bridge drive selection from the shared step clock / pwm pin
`timescale 1ns/10ps
`default_nettype none
module msd_drive_ctrl (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       pwm_mode,
   input  wire logic       brake_sel,
   input  wire logic       standby_sel,
   input  wire logic       step_clock_or_pwm_input,
   input  wire logic       drive_fwd,
   input  wire logic       drive_rev,
   output logic      [1:0] bridge,
   output logic            step_clock
);

   logic [1:0] next_bridge;
   logic       next_step_clock;
   logic [1:0] logic_pair;

   ////////////////////////////////////////////////////////////////////////////
   // forward/reverse logic, both or neither requested rests in standby
   always_comb begin
      if (drive_fwd && !drive_rev) begin
         logic_pair = msd_pkg::BRIDGE_FWD;
      end else if (drive_rev && !drive_fwd) begin
         logic_pair = msd_pkg::BRIDGE_REV;
      end else begin
         logic_pair = msd_pkg::BRIDGE_STBY;
      end
   end

   // pin overrides only in pwm use; brake wins if both options are set
   always_comb begin
      next_bridge     = logic_pair;
      next_step_clock = 1'b0;
      if (!pwm_mode) begin
         next_step_clock = step_clock_or_pwm_input;
      end else if (step_clock_or_pwm_input && brake_sel) begin
         next_bridge = msd_pkg::BRIDGE_BRAKE;
      end else if (step_clock_or_pwm_input && standby_sel) begin
         next_bridge = msd_pkg::BRIDGE_STBY;
      end
   end

   // outputs registered so the bridge never sees a decode glitch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bridge     <= msd_pkg::BRIDGE_STBY;
         step_clock <= 1'b0;
      end else begin
         bridge     <= next_bridge;
         step_clock <= next_step_clock;
      end
   end

endmodule : msd_drive_ctrl
`default_nettype wire

// [dv/msd_checker_assertions.sv]
// concurrent checks on the setting decoder ports
`timescale 1ns/10ps
`default_nettype none
module msd_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        ch5_parallel_ctrl_a,
   input wire logic        ch5_parallel_ctrl_b,
   input wire logic        ch6_parallel_ctrl_a,
   input wire logic        ch6_parallel_ctrl_b,
   input wire logic        step_clock_or_pwm_input,
   input wire logic [3:0]  ch5_current_level,
   input wire logic [3:0]  ch6_current_level,
   input wire logic        photosensor_drive_output,
   input wire logic        schmitt_buffer_one_hyst,
   input wire logic        schmitt_buffer_two_hyst,
   input wire logic        schmitt_buffer_three_hyst,
   input wire logic        step_clock_out,
   input wire logic [1:0]  bridge_out
);
   ////////////////////////////////////////////////////////////
   // setting word taken at this edge, split by kind
   wire logic wr   = psel & penable & pready & pwrite & (paddr == 8'h00) & pstrb[0];
   wire logic cur  = wr & (pwdata[2:0] == msd_pkg::MODE_CURRENT);
   wire logic cur5 = cur & ~pwdata[7];
   wire logic cur6 = cur & pwdata[7];
   wire logic drw  = wr & (pwdata[2:0] == msd_pkg::MODE_DRIVE);
   logic pwm_m, brk_m, stb_m;
   logic next_pwm_m, next_brk_m, next_stb_m;

   // mirror of the drive options, needed since they never reach a port
   always_comb begin
      {next_pwm_m, next_brk_m, next_stb_m} = {pwm_m, brk_m, stb_m};
      if (drw) {next_pwm_m, next_brk_m, next_stb_m} = {pwdata[3], pwdata[4], pwdata[5]};
   end
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) {pwm_m, brk_m, stb_m} <= 3'h0;
      else {pwm_m, brk_m, stb_m} <= {next_pwm_m, next_brk_m, next_stb_m};

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   ready_access_a: assert property (psel && !penable ##1 psel && penable |-> pready)
      else $error("no ready in access cycle");
   ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
   unmapped_err_a: assert property (psel && penable && pready && paddr > 8'h08 |-> pslverr)
      else $error("unmapped access without error");
   ch5_drop_a: assert property (cur5 && (ch5_parallel_ctrl_a || ch5_parallel_ctrl_b)
      |=> $stable(ch5_current_level)) else $error("ch5 level changed while gated");
   ch5_take_a: assert property (cur5 && !ch5_parallel_ctrl_a && !ch5_parallel_ctrl_b
      |=> ch5_current_level == $past(pwdata[6:3])) else $error("ch5 level not taken");
   ch6_drop_a: assert property (cur6 && (ch6_parallel_ctrl_a || ch6_parallel_ctrl_b)
      |=> $stable(ch6_current_level)) else $error("ch6 level changed while gated");
   ch6_take_a: assert property (cur6 && !ch6_parallel_ctrl_a && !ch6_parallel_ctrl_b
      |=> ch6_current_level == $past(pwdata[6:3])) else $error("ch6 level not taken");
   step_follow_a: assert property (1'b1 |=> step_clock_out ==
      ($past(step_clock_or_pwm_input) & ~$past(pwm_m))) else $error("step clock wrong");
   brake_force_a: assert property (pwm_m && brk_m && step_clock_or_pwm_input
      |=> bridge_out == msd_pkg::BRIDGE_BRAKE) else $error("brake not forced");
   stby_force_a: assert property (pwm_m && !brk_m && stb_m && step_clock_or_pwm_input
      |=> bridge_out == msd_pkg::BRIDGE_STBY) else $error("standby not forced");
   aux_take_a: assert property (wr && pwdata[2:0] == msd_pkg::MODE_AUX |=>
      {schmitt_buffer_three_hyst, schmitt_buffer_two_hyst, schmitt_buffer_one_hyst,
       photosensor_drive_output} == $past(pwdata[6:3])) else $error("aux bits not taken");
endmodule : msd_checker

bind msd_top msd_checker msd_checker_inst (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pstrb, .pready, .pslverr, .ch5_parallel_ctrl_a, .ch5_parallel_ctrl_b,
   .ch6_parallel_ctrl_a, .ch6_parallel_ctrl_b, .step_clock_or_pwm_input,
   .ch5_current_level, .ch6_current_level, .photosensor_drive_output,
   .schmitt_buffer_one_hyst, .schmitt_buffer_two_hyst, .schmitt_buffer_three_hyst,
   .step_clock_out, .bridge_out);
`default_nettype wire

// [dv/msd_host.sv]
// host controller model: apb master plus parallel and pin drive
`timescale 1ns/10ps
`default_nettype none
module msd_host (
   input  wire logic        pclk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [7:0]  paddr,
   output logic      [31:0] pwdata,
   output logic      [3:0]  pstrb,
   output logic             ch5_parallel_ctrl_a,
   output logic             ch5_parallel_ctrl_b,
   output logic             ch6_parallel_ctrl_a,
   output logic             ch6_parallel_ctrl_b,
   output logic             step_clock_or_pwm_input,
   output logic             drive_fwd,
   output logic             drive_rev
);
   // idle bus and all parallel lines low at start
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      pstrb = 4'hf;
      {ch5_parallel_ctrl_a, ch5_parallel_ctrl_b, ch6_parallel_ctrl_a} = 3'h0;
      {ch6_parallel_ctrl_b, step_clock_or_pwm_input, drive_fwd, drive_rev} = 4'h0;
   end

   ////////////////////////////////////////////////////////////
   // one transfer, entered just after an edge; leaves an idle cycle
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // waits as long as the slave needs; only the bench watchdog ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   // parallel inputs and pin, {ch5 a b, ch6 a b, pin, fwd, rev}
   task automatic pins(input logic [6:0] v);
      {ch5_parallel_ctrl_a, ch5_parallel_ctrl_b, ch6_parallel_ctrl_a} <= v[6:4];
      {ch6_parallel_ctrl_b, step_clock_or_pwm_input, drive_fwd, drive_rev} <= v[3:0];
   endtask : pins
endmodule : msd_host
`default_nettype wire

// [dv/msd_top_tb.sv]
// self-checking bench for the serial setting decoder
`timescale 1ns/10ps
`default_nettype none
module msd_top_tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb, ch5_current_level, ch6_current_level, l5, l6;
   logic        ch5_parallel_ctrl_a, ch5_parallel_ctrl_b, ch6_parallel_ctrl_a;
   logic        ch6_parallel_ctrl_b, step_clock_or_pwm_input, drive_fwd, drive_rev;
   logic        photosensor_drive_output, schmitt_buffer_one_hyst, er, ph;
   logic        schmitt_buffer_two_hyst, schmitt_buffer_three_hyst, step_clock_out;
   logic [1:0]  bridge_out, k;
   logic [2:0]  drv, hy;
   logic [7:0]  disc, w, sw;
   int          seed = 54500;
   int          fails = 0;
   int          check_count = 0;

   msd_top msd_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .prdata, .pready, .pslverr, .ch5_parallel_ctrl_a, .ch5_parallel_ctrl_b,
      .ch6_parallel_ctrl_a, .ch6_parallel_ctrl_b, .step_clock_or_pwm_input, .drive_fwd,
      .drive_rev, .ch5_current_level, .ch6_current_level, .photosensor_drive_output,
      .schmitt_buffer_one_hyst, .schmitt_buffer_two_hyst, .schmitt_buffer_three_hyst,
      .step_clock_out, .bridge_out);
   msd_host msd_host_inst (.pclk, .pready, .prdata, .pslverr, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .ch5_parallel_ctrl_a, .ch5_parallel_ctrl_b,
      .ch6_parallel_ctrl_a, .ch6_parallel_ctrl_b, .step_clock_or_pwm_input, .drive_fwd,
      .drive_rev);

   ////////////////////////////////////////////////////////////
   // 10 mhz clock
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // drv is {standby, brake, pwm}; brake wins over standby
   function automatic logic [1:0] exp_bridge(input logic [2:0] d, input logic p, f, r);
      if (d[0] && p && d[1]) return msd_pkg::BRIDGE_BRAKE;
      if (d[0] && p && d[2]) return msd_pkg::BRIDGE_STBY;
      if (f && !r) return msd_pkg::BRIDGE_FWD;
      if (r && !f) return msd_pkg::BRIDGE_REV;
      return msd_pkg::BRIDGE_STBY;
   endfunction : exp_bridge

   // send one setting word and follow it in the expected state
   task automatic put(input logic [7:0] v);
      logic open;
      open = v[7] ? !ch6_parallel_ctrl_a && !ch6_parallel_ctrl_b
                  : !ch5_parallel_ctrl_a && !ch5_parallel_ctrl_b;
      msd_host_inst.apb(1'b1, msd_pkg::ADDR_SETTING, {24'h0, v}, rd, er);
      sw = v;   // last word, read back in check_all
      if (v[2:0] == msd_pkg::MODE_CURRENT) begin
         if (!open) disc = (disc == 8'hff) ? disc : disc + 8'h01;
         else if (v[7]) l6 = v[6:3];
         else l5 = v[6:3];
      end
      if (v[2:0] == msd_pkg::MODE_AUX) {hy, ph} = v[6:3];
      if (v[2:0] == msd_pkg::MODE_DRIVE) drv = v[5:3];
   endtask : put

   // outputs, then status and drop counter over the bus
   task automatic check_all;
      repeat (2) @(posedge pclk);
      chk(ch5_current_level, l5);
      chk(ch6_current_level, l6);
      chk({schmitt_buffer_three_hyst, schmitt_buffer_two_hyst, schmitt_buffer_one_hyst,
           photosensor_drive_output}, {hy, ph});
      chk(bridge_out, exp_bridge(drv, step_clock_or_pwm_input, drive_fwd, drive_rev));
      chk(step_clock_out, step_clock_or_pwm_input & !drv[0]);
      msd_host_inst.apb(1'b0, msd_pkg::ADDR_STATUS, 32'h0, rd, er);
      chk(rd, {17'h0, drv, hy, ph, l6, l5});
      msd_host_inst.apb(1'b0, msd_pkg::ADDR_DISCARD, 32'h0, rd, er);
      chk(rd, {24'h0, disc});
      msd_host_inst.apb(1'b0, msd_pkg::ADDR_SETTING, 32'h0, rd, er);
      chk(rd, {24'h0, sw});
   endtask : check_all

   task automatic report_and_stop;
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : report_and_stop

   // hang guard, about five times the expected run
   initial begin
      #3000000;
      fails++;
      report_and_stop();
   end

   initial begin
      {l5, l6, drv, hy, ph, disc, sw} = '0;
      presetn = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // reset values, then one unmapped word
      for (int a = 0; a < 16; a += 4) begin
         msd_host_inst.apb(1'b0, 8'(a), 32'h0, rd, er);
         chk(rd, 32'h0);
         chk(er, a == 12);
      end
      // random pins and words, mostly in the three decoded modes
      for (int i = 0; i < 300; i++) begin
         msd_host_inst.pins(7'($random(seed)));
         @(posedge pclk);
         w = 8'($random(seed));
         k = 2'($random(seed));
         if (k != 2'h3) w[2:0] = (k == 2'h0) ? msd_pkg::MODE_CURRENT :
                                 (k == 2'h1) ? msd_pkg::MODE_AUX : msd_pkg::MODE_DRIVE;
         put(w);
         check_all();
      end
      // ch5 gated long enough to saturate the drop counter
      msd_host_inst.pins(7'h40);
      @(posedge pclk);
      repeat (260) put(8'h7e);
      check_all();
      // status is read only, any counter write clears it
      msd_host_inst.apb(1'b1, msd_pkg::ADDR_STATUS, 32'hffffffff, rd, er);
      msd_host_inst.apb(1'b1, msd_pkg::ADDR_DISCARD, 32'h0, rd, er);
      disc = 8'h00;
      check_all();
      report_and_stop();
   end
endmodule : msd_top_tb
`default_nettype wire
